// ### include/sdio_cmd_pkg.sv
// Constants shared by the SDIO command capture block.
package sdio_cmd_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DT_ADDR  = 8'h04;
  localparam logic [7:0] OFS_CMD_ADDR = 8'h08;
  localparam logic [7:0] OFS_BLK_CNT  = 8'h0c;
  localparam logic [7:0] OFS_BYTE_CNT = 8'h10;
  localparam logic [7:0] OFS_CMD_INFO = 8'h14;
  localparam logic [7:0] OFS_EVENT    = 8'h18;
  localparam logic [7:0] OFS_BLK_SIZE = 8'h20;
  localparam logic [7:0] OFS_BLK_LAST = 8'h3c;
  // Control register fields and reset value.
  localparam int CTRL_DT_EN  = 0;
  localparam int CTRL_DT_INC = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // Event register fields.
  localparam int EV_CMD     = 0;
  localparam int EV_CD_RISE = 1;
  localparam int EV_CD_FALL = 2;
  localparam int EV_DT_END  = 3;
  // Command information fields.
  localparam int INFO_CMD53 = 0;
  localparam int INFO_WRITE = 1;
  localparam int INFO_RAW   = 2;
  localparam int INFO_BLOCK = 3;
  localparam int INFO_INC   = 4;
  // Command frame layout.
  localparam logic [5:0] FRAME_LAST = 6'h2f;
  localparam logic [5:0] IDX_RW_DIRECT = 6'h34;
  localparam logic [5:0] IDX_RW_EXTEND = 6'h35;
  localparam int ARG_RW = 31;
  localparam int ARG_FN_LO = 28;
  localparam int ARG_MODE = 27;
  localparam int ARG_OP = 26;
  localparam int ARG_ADDR_LO = 9;
  // Captured field widths and values.
  localparam int ADDR_BITS = 17;
  localparam int BLK_BITS = 9;
  localparam int BYTE_BITS = 12;
  localparam logic [11:0] BYTE_ZERO_CNT = 12'h200;
  localparam logic [11:0] BLK_SIZE_RST  = 12'h200;
  // On-chip RAM window for the direct-transfer start address.
  localparam logic [31:0] RAM_BASE = 32'h0000_0000;
  localparam logic [31:0] RAM_TOP  = 32'h0003_ffff;
  localparam logic [31:0] DT_ADDR_RST = 32'h0000_0000;
endpackage

// ### include/pin_sync_if.sv
// Synchronised pin level and its edges.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport producer (output level, output rise, output fall);
  modport consumer (input level, input rise, input fall);
endinterface
`default_nettype wire

// ### rtl/pin_sync.sv
// Three-flop pin synchroniser with filtered level and edge pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset.
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  // Raw pin.
  input  wire logic i_pin,
  // Synchronised result.
  pin_sync_if.producer sync
);
  logic       s1;
  logic       s2;
  logic       s3;
  logic [1:0] fill;

  // Shift chain; only the second flop reads the first.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Counts edges until the third flop holds a real pin sample, so the reset
  // value of the chain never shows up as a false edge on a pin idling high.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fill <= 2'h0;
    end else if (fill != 2'h3) begin
      fill <= fill + 2'h1;
    end
  end

  // A change counts once the second and third flops agree.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync.level <= 1'b0;
      sync.rise  <= 1'b0;
      sync.fall  <= 1'b0;
    end else if (fill != 2'h3) begin
      // Chain still filling: follow the pin, report no edge.
      sync.level <= s2;
      sync.rise  <= 1'b0;
      sync.fall  <= 1'b0;
    end else begin
      sync.rise <= (s2 == s3) && s2 && !sync.level;
      sync.fall <= (s2 == s3) && !s2 && sync.level;
      if (s2 == s3) begin
        sync.level <= s2;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/sdio_cmd_capture.sv
// SDIO slave command capture, data routing and event registers.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sdio_cmd_capture
  import sdio_cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // Register port.
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [31:0] o_rdata,
  // SD bus pins and card-detect-disable level.
  input  wire logic        i_sd_clk,
  input  wire logic        i_sd_cmd,
  input  wire logic        i_card_detect_off,
  // Deserialised data stream from the data lines.
  input  wire logic        i_data_valid,
  input  wire logic [7:0]  i_data_byte,
  input  wire logic        i_word_req,
  // Memory side: RAM path for function 1 when enabled, otherwise the area at the command address.
  output var  logic        o_mem_we,
  output var  logic        o_mem_re,
  output var  logic        o_mem_to_ram,
  output var  logic [31:0] o_mem_addr,
  output var  logic [31:0] o_mem_wdata,
  output var  logic [3:0]  o_mem_be
);

  pin_sync_if clk_s ();
  pin_sync_if cmd_s ();
  pin_sync_if cd_s ();

  // Pin synchronisers for the SD clock, command line and detect level.
  pin_sync u_clk (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_sd_clk),
    .sync       (clk_s.producer)
  );
  pin_sync u_cmd (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_sd_cmd),
    .sync       (cmd_s.producer)
  );
  pin_sync u_cd (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_card_detect_off),
    .sync       (cd_s.producer)
  );

  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_t;

  rx_state_t               rx_state;
  logic [47:0]             frame;
  logic [5:0]              bit_cnt;
  logic                    frame_done;
  logic [1:0]              ctrl;
  logic [31:0]             dt_addr;
  logic [ADDR_BITS-1:0]    cmd_addr;
  logic [BLK_BITS-1:0]     blk_cnt;
  logic [BYTE_BITS-1:0]    byte_cnt;
  logic [4:0]              cmd_info;
  logic [3:0]              events;
  logic [BYTE_BITS-1:0]    blk_size [8];
  logic                    xfer_on;
  logic                    xfer_write;
  logic                    xfer_ram;
  logic                    xfer_inc;
  logic                    xfer_endless;
  logic [20:0]             xfer_rem;
  logic [31:0]             xfer_ptr;
  logic [31:0]             pack_word;
  logic [1:0]              pack_n;

  // Fields of the received frame.
  logic [5:0]  f_index;
  logic [31:0] f_arg;
  logic [2:0]  f_fn;
  logic        f_ok;
  logic        is_direct;
  logic        is_extend;
  logic        f_block;
  logic [8:0]  f_cnt;
  logic [BYTE_BITS-1:0] next_byte_cnt;
  logic [20:0] next_len;

  assign f_index   = frame[45:40];
  assign f_arg     = frame[39:8];
  assign f_fn      = f_arg[ARG_FN_LO+2:ARG_FN_LO];
  assign f_ok      = frame_done && frame[46] && frame[0];
  assign is_direct = f_ok && (f_index == IDX_RW_DIRECT);
  assign is_extend = f_ok && (f_index == IDX_RW_EXTEND);
  assign f_block   = f_arg[ARG_MODE];
  assign f_cnt     = f_arg[8:0];

  // Byte count and transfer length of an extended command.
  always_comb begin
    if (f_block) begin
      next_byte_cnt = blk_size[f_fn];
      next_len = 21'(f_cnt) * 21'(blk_size[f_fn]);
    end else begin
      next_byte_cnt = (f_cnt == 9'h000) ? BYTE_ZERO_CNT
                                        : BYTE_BITS'(f_cnt);
      next_len = 21'(next_byte_cnt);
    end
  end

  // Command line receiver, sampled on SD clock rising edges.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_state   <= RX_IDLE;
      frame      <= 48'h0;
      bit_cnt    <= 6'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (clk_s.rise) begin
        unique case (rx_state)
          RX_IDLE: begin
            if (!cmd_s.level) begin
              rx_state <= RX_FRAME;
              frame    <= {frame[46:0], 1'b0};
              bit_cnt  <= 6'h01;
            end
          end
          RX_FRAME: begin
            frame   <= {frame[46:0], cmd_s.level};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == FRAME_LAST) begin
              rx_state   <= RX_IDLE;
              frame_done <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Captured command information, all updated in one cycle.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_addr <= '0;
      blk_cnt  <= '0;
      byte_cnt <= '0;
      cmd_info <= 5'h00;
    end else if (is_direct || is_extend) begin
      cmd_addr <= f_arg[ARG_ADDR_LO+ADDR_BITS-1:ARG_ADDR_LO];
      cmd_info[INFO_CMD53] <= is_extend;
      cmd_info[INFO_WRITE] <= f_arg[ARG_RW];
      if (is_extend) begin
        blk_cnt  <= f_block ? f_cnt : 9'h000;
        byte_cnt <= next_byte_cnt;
        cmd_info[INFO_RAW]   <= 1'b0;
        cmd_info[INFO_BLOCK] <= f_block;
        cmd_info[INFO_INC]   <= f_arg[ARG_OP];
      end else begin
        blk_cnt  <= 9'h000;
        byte_cnt <= 12'h001;
        cmd_info[INFO_RAW]   <= f_arg[ARG_MODE];
        cmd_info[INFO_BLOCK] <= 1'b0;
        cmd_info[INFO_INC]   <= 1'b0;
      end
    end
  end

  // Software-owned control, start address and block sizes.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl    <= CTRL_RST;
      dt_addr <= DT_ADDR_RST;
      for (int i = 0; i < 8; i++) begin
        blk_size[i] <= BLK_SIZE_RST;
      end
    end else if (i_wr) begin
      if (i_addr == OFS_CTRL) begin
        ctrl <= i_wdata[1:0];
      end
      // Addresses outside on-chip RAM are refused.
      if (i_addr == OFS_DT_ADDR && i_wdata >= RAM_BASE &&
          i_wdata <= RAM_TOP) begin
        dt_addr <= {i_wdata[31:2], 2'b00};
      end
      if (i_addr >= OFS_BLK_SIZE && i_addr <= OFS_BLK_LAST &&
          i_addr[1:0] == 2'b00) begin
        blk_size[i_addr[4:2]] <= i_wdata[BYTE_BITS-1:0];
      end
    end
  end

  // Sticky events; write one to clear, a new event wins over a clear.
  logic [3:0] ev_set;
  logic       dt_done;
  assign ev_set[EV_CMD]     = is_extend ||
                              (is_direct && f_arg[ARG_RW]);
  assign ev_set[EV_CD_RISE] = cd_s.rise;
  assign ev_set[EV_CD_FALL] = cd_s.fall;
  assign ev_set[EV_DT_END]  = dt_done;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      events <= 4'h0;
    end else begin
      if (i_wr && i_addr == OFS_EVENT) begin
        events <= (events & ~i_wdata[3:0]) | ev_set;
      end else begin
        events <= events | ev_set;
      end
    end
  end

  // Register read data, valid in the cycle after the read strobe.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      o_rdata <= 32'h0;
      if (i_addr >= OFS_BLK_SIZE && i_addr <= OFS_BLK_LAST &&
          i_addr[1:0] == 2'b00) begin
        o_rdata <= {20'h0, blk_size[i_addr[4:2]]};
      end else begin
        unique case (i_addr)
          OFS_CTRL:     o_rdata <= {30'h0, ctrl};
          OFS_DT_ADDR:  o_rdata <= dt_addr;
          OFS_CMD_ADDR: o_rdata <= {15'h0, cmd_addr};
          OFS_BLK_CNT:  o_rdata <= {23'h0, blk_cnt};
          OFS_BYTE_CNT: o_rdata <= {20'h0, byte_cnt};
          OFS_CMD_INFO: o_rdata <= {27'h0, cmd_info};
          OFS_EVENT:    o_rdata <= {28'h0, events};
          default:      o_rdata <= 32'h0;
        endcase
      end
    end
  end

  // Byte count of the current word and its last-word test.
  logic       last_byte;
  logic [2:0] rd_take;
  logic       last_word;
  logic [3:0] rd_be;
  assign last_byte = !xfer_endless && (xfer_rem == 21'h1);
  assign rd_take   = (xfer_endless || xfer_rem > 21'h3) ? 3'h4
                                                        : 3'(xfer_rem);
  assign last_word = !xfer_endless && (xfer_rem <= 21'h4);
  assign rd_be     = 4'((5'h01 << rd_take) - 5'h01);

  // Transfer engine: routes extended-command data and tracks its end.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xfer_on      <= 1'b0;
      xfer_write   <= 1'b0;
      xfer_ram     <= 1'b0;
      xfer_inc     <= 1'b0;
      xfer_endless <= 1'b0;
      xfer_rem     <= 21'h0;
      xfer_ptr     <= 32'h0;
      pack_word    <= 32'h0;
      pack_n       <= 2'h0;
      dt_done      <= 1'b0;
      o_mem_we     <= 1'b0;
      o_mem_re     <= 1'b0;
      o_mem_to_ram <= 1'b0;
      o_mem_addr   <= 32'h0;
      o_mem_wdata  <= 32'h0;
      o_mem_be     <= 4'h0;
    end else begin
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      dt_done  <= 1'b0;
      if (is_extend) begin
        xfer_on      <= 1'b1;
        xfer_write   <= f_arg[ARG_RW];
        xfer_endless <= f_block && (f_cnt == 9'h000);
        xfer_rem     <= next_len;
        pack_n       <= 2'h0;
        pack_word    <= 32'h0;
        if (ctrl[CTRL_DT_EN] && f_fn == 3'h1) begin
          xfer_ram <= 1'b1;
          xfer_inc <= ctrl[CTRL_DT_INC];
          xfer_ptr <= dt_addr;
        end else begin
          xfer_ram <= 1'b0;
          xfer_inc <= f_arg[ARG_OP];
          xfer_ptr <= {15'h0, f_arg[ARG_ADDR_LO+ADDR_BITS-1:ARG_ADDR_LO]};
        end
      end else if (xfer_on && xfer_write && i_data_valid) begin
        // Host write: pack bytes little-endian into words.
        pack_word[pack_n*8 +: 8] <= i_data_byte;
        pack_n   <= pack_n + 2'h1;
        xfer_rem <= xfer_endless ? xfer_rem : xfer_rem - 21'h1;
        if (pack_n == 2'h3 || last_byte) begin
          o_mem_we     <= 1'b1;
          o_mem_to_ram <= xfer_ram;
          o_mem_addr   <= xfer_ptr;
          o_mem_wdata  <= pack_word;
          o_mem_wdata[pack_n*8 +: 8] <= i_data_byte;
          o_mem_be     <= 4'((5'h02 << pack_n) - 5'h01);
          pack_n       <= 2'h0;
          pack_word    <= 32'h0;
          if (xfer_inc) begin
            xfer_ptr <= xfer_ptr + 32'h4;
          end
        end
        if (last_byte) begin
          xfer_on <= 1'b0;
          dt_done <= xfer_ram;
        end
      end else if (xfer_on && !xfer_write && i_word_req) begin
        // Host read: fetch one word per request.
        o_mem_re     <= 1'b1;
        o_mem_to_ram <= xfer_ram;
        o_mem_addr   <= xfer_ptr;
        o_mem_be     <= rd_be;
        xfer_rem     <= xfer_endless ? xfer_rem : xfer_rem - 21'(rd_take);
        if (xfer_inc) begin
          xfer_ptr <= xfer_ptr + 32'h4;
        end
        if (last_word) begin
          xfer_on <= 1'b0;
          dt_done <= xfer_ram;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/sdio_cmd_capture_checker.sv
// Port-level assertions for the SDIO command capture block.
`timescale 1ns/1ps
`default_nettype none
module sdio_cmd_capture_checker
  import sdio_cmd_pkg::*;
(
  // Clock and reset.
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  // Register port.
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // SD side and data stream.
  input wire logic        i_sd_clk,
  input wire logic        i_sd_cmd,
  input wire logic        i_card_detect_off,
  input wire logic        i_data_valid,
  input wire logic [7:0]  i_data_byte,
  input wire logic        i_word_req,
  // Memory side.
  input wire logic        o_mem_we,
  input wire logic        o_mem_re,
  input wire logic        o_mem_to_ram,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic [3:0]  o_mem_be
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Read data carries only the valid width of each captured field.
  info_reserved_a: assert property (
    $past(i_rd) && $past(i_addr) == OFS_CMD_INFO |-> o_rdata[31:5] == 27'h0)
    else $error("info reserved bits set");
  cmd_addr_width_a: assert property (
    $past(i_rd) && $past(i_addr) == OFS_CMD_ADDR |-> o_rdata[31:17] == 15'h0)
    else $error("command address too wide");
  blk_width_a: assert property (
    $past(i_rd) && $past(i_addr) == OFS_BLK_CNT |-> o_rdata[31:9] == 23'h0)
    else $error("block count too wide");
  byte_width_a: assert property (
    $past(i_rd) && $past(i_addr) == OFS_BYTE_CNT |-> o_rdata[31:12] == 20'h0)
    else $error("byte count too wide");
  dt_addr_range_a: assert property (
    $past(i_rd) && $past(i_addr) == OFS_DT_ADDR
      |-> o_rdata <= RAM_TOP && o_rdata[1:0] == 2'h0)
    else $error("start address outside RAM");
  // Read data holds between reads.
  rdata_hold_a: assert property (
    !$past(i_rd) |-> $stable(o_rdata)) else $error("read data moved");
  // Memory strobes follow their stream requests by one cycle.
  mem_wr_cause_a: assert property (
    o_mem_we |-> $past(i_data_valid)) else $error("write without byte");
  mem_rd_cause_a: assert property (
    o_mem_re |-> $past(i_word_req)) else $error("read without request");
  mem_be_a: assert property (
    o_mem_we || o_mem_re |-> o_mem_be != 4'h0) else $error("empty lanes");
endmodule
bind sdio_cmd_capture sdio_cmd_capture_checker chk (.i_core_clk, .i_reset_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sd_clk, .i_sd_cmd,
  .i_card_detect_off, .i_data_valid, .i_data_byte, .i_word_req, .o_mem_we,
  .o_mem_re, .o_mem_to_ram, .o_mem_addr, .o_mem_wdata, .o_mem_be);
`default_nettype wire

// ### verif/sd_host_model.sv
// Behavioural SD host that sends command frames on the command line.
`timescale 1ns/1ps
`default_nettype none
module sd_host_model (
  // SD bus clock and command line.
  output var logic o_sd_clk,
  output var logic o_sd_cmd
);
  // Clock stands low and the pulled-up line idles high between frames.
  initial begin
    o_sd_clk = 1'b0;
    o_sd_cmd = 1'b1;
  end
  // Sends start, transmission bit, index, argument, filler check, end bit.
  // Pins change by non-blocking assignment, so a core edge at the same
  // instant still sees the old level.
  task automatic send(input logic [5:0] idx, input logic [31:0] arg,
                      input logic end_bit);
    logic [47:0] f;
    f = {2'b01, idx, arg, 7'h55, end_bit};
    for (int i = 47; i >= 0; i--) begin
      o_sd_cmd <= f[i];
      #40 o_sd_clk <= 1'b1;
      #40 o_sd_clk <= 1'b0;
    end
    o_sd_cmd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verif/sdio_slave_command_capture_bench.sv
// Self-checking bench for the SDIO command capture block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module sdio_slave_command_capture_bench;
  import sdio_cmd_pkg::*;
  typedef struct packed {
    logic [5:0]  idx;
    logic [31:0] arg;
    logic [7:0]  info;
    logic        ev;
    logic [16:0] adr;
    logic [8:0]  blk;
    logic [11:0] byt;
  } row_t;
  logic i_core_clk, i_reset_n, i_wr, i_rd, i_sd_clk, i_sd_cmd;
  logic i_card_detect_off, i_data_valid, i_word_req;
  logic o_mem_we, o_mem_re, o_mem_to_ram;
  logic [7:0] i_addr, i_data_byte;
  logic [31:0] i_wdata, o_rdata, o_mem_addr, o_mem_wdata;
  logic [3:0] o_mem_be;
  logic [69:0] q[$];
  int error_cnt = 0;
  int n_checks = 0;
  row_t rows [4] = '{
    '{IDX_RW_DIRECT, 32'h9ab4b43c, 8'h06, 1'b1, 17'h15a5a, 9'h0, 12'h001},
    '{IDX_RW_DIRECT, 32'h00000e00, 8'h00, 1'b0, 17'h00007, 9'h0, 12'h001},
    '{IDX_RW_EXTEND, 32'h14024600, 8'h11, 1'b1, 17'h00123, 9'h0, 12'h200},
    '{IDX_RW_EXTEND, 32'habffffff, 8'h0b, 1'b1, 17'h1ffff, 9'h1ff, 12'h040}};
  sdio_cmd_capture DUT (.i_core_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_sd_clk, .i_sd_cmd, .i_card_detect_off,
    .i_data_valid, .i_data_byte, .i_word_req, .o_mem_we, .o_mem_re,
    .o_mem_to_ram, .o_mem_addr, .o_mem_wdata, .o_mem_be);
  sd_host_model host (.o_sd_clk(i_sd_clk), .o_sd_cmd(i_sd_cmd));
  // Clock generator.
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Logs memory strobes mid-cycle, keeping only the enabled write lanes.
  always @(negedge i_core_clk) begin
    if (o_mem_we || o_mem_re) begin
      q.push_back({o_mem_we, o_mem_to_ram, o_mem_addr, o_mem_be,
        o_mem_wdata & {{8{o_mem_be[3]}}, {8{o_mem_be[2]}},
        {8{o_mem_be[1]}}, {8{o_mem_be[0]}}} & {32{o_mem_we}}});
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
    cyc(1);
  endtask
  task automatic cmd(input logic [5:0] i, input logic [31:0] a,
                     input logic e);
    host.send(i, a, e);
    cyc(20);
  endtask
  task automatic bytes(input int n);
    for (int k = 1; k <= n; k++) begin
      i_data_valid <= 1'b1;
      i_data_byte <= 8'(k * 17);
      cyc(1);
    end
    i_data_valid <= 1'b0;
    cyc(4);
  endtask
  task automatic pq(input logic [69:0] e);
    logic [69:0] v;
    v = (q.size() != 0) ? q.pop_front() : 70'h0;
    `CHK(v, e)
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run time.
  initial begin
    #500_000;
    error_cnt++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    {i_reset_n, i_wr, i_rd, i_card_detect_off, i_data_valid} = 5'h0;
    {i_word_req, i_addr, i_data_byte, i_wdata} = 49'h0;
    cyc(5);
    i_reset_n <= 1'b1;
    cyc(1);
    rc(OFS_CTRL, 32'h0);
    rc(OFS_DT_ADDR, DT_ADDR_RST);
    rc(OFS_CMD_INFO, 32'h0);
    rc(OFS_BLK_SIZE + 8'h08, 32'h200);
    rc(8'h1c, 32'h0);
    wr(OFS_BLK_SIZE + 8'h08, 32'h40);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_EVENT, 32'hf);
      cmd(rows[r].idx, rows[r].arg, 1'b1);
      rc(OFS_EVENT, {31'h0, rows[r].ev});
      rc(OFS_CMD_INFO, {24'h0, rows[r].info});
      rc(OFS_CMD_ADDR, {15'h0, rows[r].adr});
      rc(OFS_BYTE_CNT, {20'h0, rows[r].byt});
      if (rows[r].info[0]) rc(OFS_BLK_CNT, {23'h0, rows[r].blk});
    end
    $display("command table done");
    wr(OFS_EVENT, 32'hf);
    cmd(IDX_RW_DIRECT, rows[0].arg, 1'b0);
    cmd(6'h11, rows[0].arg, 1'b1);
    wr(OFS_CMD_INFO, 32'hff);
    rc(OFS_EVENT, 32'h0);
    rc(OFS_CMD_INFO, 32'h0b);
    $display("refused frames done");
    i_card_detect_off <= 1'b1;
    cyc(8);
    rc(OFS_EVENT, 32'h2);
    wr(OFS_EVENT, 32'h2);
    rc(OFS_EVENT, 32'h0);
    i_card_detect_off <= 1'b0;
    cyc(8);
    rc(OFS_EVENT, 32'h4);
    $display("card detect done");
    wr(OFS_CTRL, 32'h3);
    wr(OFS_DT_ADDR, 32'h100);
    wr(OFS_DT_ADDR, 32'h40000);
    rc(OFS_DT_ADDR, 32'h100);
    wr(OFS_EVENT, 32'hf);
    cmd(IDX_RW_EXTEND, 32'h94000005, 1'b1);
    bytes(5);
    pq({2'b11, 32'h100, 4'hf, 32'h44332211});
    pq({2'b11, 32'h104, 4'h1, 32'h55});
    rc(OFS_EVENT, 32'h9);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_EVENT, 32'hf);
    cmd(IDX_RW_EXTEND, 32'h94000005, 1'b1);
    bytes(5);
    pq({2'b11, 32'h100, 4'hf, 32'h44332211});
    pq({2'b11, 32'h100, 4'h1, 32'h55});
    rc(OFS_EVENT, 32'h9);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_EVENT, 32'hf);
    cmd(IDX_RW_EXTEND, 32'h90008004, 1'b1);
    bytes(4);
    pq({2'b10, 32'h40, 4'hf, 32'h44332211});
    rc(OFS_EVENT, 32'h1);
    cmd(IDX_RW_EXTEND, 32'h10008002, 1'b1);
    i_word_req <= 1'b1;
    cyc(1);
    i_word_req <= 1'b0;
    cyc(3);
    pq({2'b00, 32'h40, 4'h3, 32'h0});
    cmd(IDX_RW_EXTEND, 32'h14008006, 1'b1);
    i_word_req <= 1'b1;
    cyc(2);
    i_word_req <= 1'b0;
    cyc(3);
    pq({2'b00, 32'h40, 4'hf, 32'h0});
    pq({2'b00, 32'h44, 4'h3, 32'h0});
    `CHK(q.size(), 0)
    $display("data paths done");
    i_card_detect_off <= 1'b1;
    i_reset_n <= 1'b0;
    cyc(2);
    i_reset_n <= 1'b1;
    cyc(8);
    rc(OFS_EVENT, 32'h0);
    rc(OFS_CTRL, 32'h0);
    rc(OFS_CMD_INFO, 32'h0);
    rc(OFS_BYTE_CNT, 32'h0);
    $display("reset cases done");
    report_and_stop();
  end
endmodule
`default_nettype wire
